// >>> logic/psl_pkg.sv
// shared constants, types and helpers of the port 1 strap default loader
package psl_pkg;

    // strap fallback values, held in the strap flops from reset until the pins are captured
    localparam logic DUPLEX_STRAP_RESET = 1'b1;
    localparam logic BACKPRESSURE_STRAP_RESET = 1'b1;
    localparam logic FD_FLOW_STRAP_RESET = 1'b1;
    localparam logic MANUAL_FLOW_STRAP_RESET = 1'b0;
    localparam logic EEE_STRAP_RESET = 1'b0;

    // settle time after reset release, covers the two synchroniser stages
    localparam int SETTLE_NS = 15;
    localparam int CLK_PERIOD_NS = 5;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = 3;

    // strap pin vector positions after synchronisation
    localparam int PIN_DUPLEX_STRAP = 0;
    localparam int PIN_BACKPRESSURE = 1;
    localparam int PIN_FD_FLOW = 2;
    localparam int PIN_MANUAL_FLOW = 3;
    localparam int PIN_EEE = 4;
    localparam int PIN_PORT1_DUPLEX = 5;
    localparam int PIN_COUNT = 6;

    // partner ability field positions
    localparam int ABIL_10T_HD = 0;
    localparam int ABIL_10T_FD = 1;
    localparam int ABIL_100X_HD = 2;
    localparam int ABIL_100X_FD = 3;
    localparam int ABIL_PAUSE = 4;
    localparam int ABIL_ASYM_PAUSE = 5;
    localparam int ABIL_W = 6;

    // port 1 operating modes
    typedef enum logic [1:0] {
        PSL_MODE_INTERNAL_PHY,
        PSL_MODE_MII_MAC,
        PSL_MODE_RMII_MAC,
        PSL_MODE_MII_PHY
    } psl_port_mode_e;

    // loader sequence
    typedef enum logic [1:0] {
        PSL_SETTLE,
        PSL_WAIT_EEPROM,
        PSL_LOAD,
        PSL_READY
    } psl_state_e;

    // register defaults produced from the straps
    typedef struct packed {
        logic backpressure_enable;
        logic tx_flow_ctrl_enable;
        logic rx_flow_ctrl_enable;
        logic manual_flow_ctrl;
        logic energy_efficient_enable;
        logic phy_adv_asym_pause;
        logic phy_adv_sym_pause;
        logic vphy_adv_asym_pause;
        logic vphy_adv_sym_pause;
        logic [ABIL_W-1:0] vphy_partner_ability;
    } psl_defaults_s;

    // pause advertisement: manual flow control withdraws both pause bits
    function automatic logic adv_pause(input logic fd_flow, input logic manual_flow);
        adv_pause = fd_flow & ~manual_flow;
    endfunction

    // true for the two mac-facing modes where the duplex pin is honoured
    function automatic logic is_mac_mode(input psl_port_mode_e mode);
        is_mac_mode = (mode == PSL_MODE_MII_MAC) || (mode == PSL_MODE_RMII_MAC);
    endfunction

endpackage

// >>> logic/psl_strap_if.sv
// bundle of captured strap values passed between loader and mapper
`timescale 1ns/1ps
interface psl_strap_if;
    logic duplex;
    logic backpressure;
    logic fd_flow;
    logic manual_flow;
    logic eee;

    modport src (output duplex, output backpressure, output fd_flow,
        output manual_flow, output eee);
    modport snk (input duplex, input backpressure, input fd_flow,
        input manual_flow, input eee);
endinterface

// >>> logic/psl_sync.sv
// two flip-flop synchroniser for the strap and duplex pins
`timescale 1ns/1ps
module psl_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // pins and synchronised copy
    input wire logic [W-1:0] pin,
    output logic [W-1:0] pin_sync
);
    logic [W-1:0] stage1;

    // first stage is read only by the second stage
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= '0;
            pin_sync <= '0;
        end else begin
            stage1 <= pin;
            pin_sync <= stage1;
        end
    end
endmodule

// >>> logic/psl_default_map.sv
// maps captured straps and port modes onto register default bits
`timescale 1ns/1ps
module psl_default_map (
    // captured straps
    psl_strap_if.snk straps,
    // operating modes
    input wire psl_pkg::psl_port_mode_e port1_mode,
    input wire logic phya_fx_mode,
    // resulting defaults
    output psl_pkg::psl_defaults_s defaults
);
    logic eee_blocked;

    // fx on the internal phy negotiates no eee, so the strap cannot enable it
    assign eee_blocked = (port1_mode == psl_pkg::PSL_MODE_INTERNAL_PHY) && phya_fx_mode;

    always_comb begin
        defaults = '0;
        defaults.backpressure_enable = straps.backpressure;
        defaults.tx_flow_ctrl_enable = straps.fd_flow;
        defaults.rx_flow_ctrl_enable = straps.fd_flow;
        defaults.manual_flow_ctrl = straps.manual_flow;
        defaults.energy_efficient_enable = straps.eee & ~eee_blocked;
        // fx mode leaves the phy advertisement pause bits at plain zero
        if (!phya_fx_mode) begin
            defaults.phy_adv_asym_pause = psl_pkg::adv_pause(straps.fd_flow, straps.manual_flow);
            defaults.phy_adv_sym_pause = psl_pkg::adv_pause(straps.fd_flow, straps.manual_flow);
        end
        defaults.vphy_adv_asym_pause = psl_pkg::adv_pause(straps.fd_flow, straps.manual_flow);
        defaults.vphy_adv_sym_pause = psl_pkg::adv_pause(straps.fd_flow, straps.manual_flow);
        // partner mirrors the strapped duplex: full bits follow it, half bits take its inverse
        defaults.vphy_partner_ability[psl_pkg::ABIL_100X_FD] = straps.duplex;
        defaults.vphy_partner_ability[psl_pkg::ABIL_10T_FD] = straps.duplex;
        defaults.vphy_partner_ability[psl_pkg::ABIL_100X_HD] = ~straps.duplex;
        defaults.vphy_partner_ability[psl_pkg::ABIL_10T_HD] = ~straps.duplex;
        defaults.vphy_partner_ability[psl_pkg::ABIL_PAUSE] = straps.fd_flow;
        defaults.vphy_partner_ability[psl_pkg::ABIL_ASYM_PAUSE] = straps.fd_flow;
    end
endmodule

// >>> logic/psl_strap_loader.sv
// port 1 strap capture and register default loader
`timescale 1ns/1ps
module psl_strap_loader (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // strap pins, asynchronous to ref_clk
    input wire logic duplex_strap_pin,
    input wire logic port1_backpressure_strap,
    input wire logic port1_fullduplex_flow_ctrl_strap,
    input wire logic port1_manual_flow_ctrl_strap,
    input wire logic energy_efficient_strap_pin,
    input wire logic port1_duplex_pin,
    // eeprom strap image, same clock
    input wire logic eeprom_present,
    input wire logic eeprom_strap_valid,
    input wire logic eeprom_duplex_strap,
    input wire logic eeprom_backpressure_strap,
    input wire logic eeprom_fd_flow_strap,
    input wire logic eeprom_manual_flow_strap,
    // operating modes, same clock
    input wire psl_pkg::psl_port_mode_e port1_mode,
    input wire logic phya_fx_mode,
    // register access gate
    input wire logic reg_access_req,
    output logic reg_access_accept,
    output logic defaults_ready,
    // port 1 flow control defaults
    output logic port1_backpressure_enable,
    output logic port1_tx_flow_ctrl_enable,
    output logic port1_rx_flow_ctrl_enable,
    output logic port1_manual_flow_ctrl,
    // mac transmit config default
    output logic mac_energy_efficient_enable,
    // phy a advertisement defaults
    output logic phy_adv_asym_pause,
    output logic phy_adv_sym_pause,
    // virtual phy defaults
    output logic virtual_phy_adv_asym_pause,
    output logic virtual_phy_adv_sym_pause,
    output logic [psl_pkg::ABIL_W-1:0] virtual_phy_partner_ability,
    // live duplex pin interpretation
    output logic port1_pin_full_duplex
);

    logic [psl_pkg::PIN_COUNT-1:0] pins;
    logic [psl_pkg::PIN_COUNT-1:0] pins_sync;

    // every pin passes two flops before anything reads it
    // the duplex pin shares the synchroniser with the straps, though it is
    // read live after load while the straps are read only once
    assign pins[psl_pkg::PIN_DUPLEX_STRAP] = duplex_strap_pin;
    assign pins[psl_pkg::PIN_BACKPRESSURE] = port1_backpressure_strap;
    assign pins[psl_pkg::PIN_FD_FLOW] = port1_fullduplex_flow_ctrl_strap;
    assign pins[psl_pkg::PIN_MANUAL_FLOW] = port1_manual_flow_ctrl_strap;
    assign pins[psl_pkg::PIN_EEE] = energy_efficient_strap_pin;
    assign pins[psl_pkg::PIN_PORT1_DUPLEX] = port1_duplex_pin;

    psl_sync #(
        .W(psl_pkg::PIN_COUNT)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .pin(pins),
        .pin_sync(pins_sync)
    );

    // sequence state
    // the loader walks settle, optional eeprom wait, load and ready once per
    // reset; nothing moves it back, so a second capture needs a new reset
    // settle lasts long enough for both sync stages to hold pin levels
    // sampled after reset release, not the cleared reset values
    psl_pkg::psl_state_e state;
    psl_pkg::psl_state_e next_state;
    logic [psl_pkg::SETTLE_W-1:0] settle_cnt;
    logic [psl_pkg::SETTLE_W-1:0] next_settle_cnt;
    logic settle_done;

    assign settle_done = (settle_cnt == psl_pkg::SETTLE_W'(psl_pkg::SETTLE_CYCLES));

    // pins are only trusted once both sync stages hold post-reset values
    always_comb begin
        next_state = state;
        next_settle_cnt = settle_cnt;
        unique case (state)
            psl_pkg::PSL_SETTLE: begin
                if (settle_done) begin
                    next_state = eeprom_present ? psl_pkg::PSL_WAIT_EEPROM : psl_pkg::PSL_LOAD;
                end else begin
                    next_settle_cnt = settle_cnt + psl_pkg::SETTLE_W'(1);
                end
            end
            psl_pkg::PSL_WAIT_EEPROM: begin
                // eeprom image overrides pin straps, so loading waits for it
                if (eeprom_strap_valid) begin
                    next_state = psl_pkg::PSL_LOAD;
                end
            end
            psl_pkg::PSL_LOAD: begin
                next_state = psl_pkg::PSL_READY;
            end
            psl_pkg::PSL_READY: begin
                next_state = psl_pkg::PSL_READY;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= psl_pkg::PSL_SETTLE;
            settle_cnt <= '0;
        end else begin
            state <= next_state;
            settle_cnt <= next_settle_cnt;
        end
    end

    // captured strap bits
    // these hold the straps between capture and load; their reset values
    // are the strap fallbacks, which the capture at the end of settle always
    // replaces, so no default is ever loaded from them
    // the eeprom image may overwrite four of them; eee keeps its pin value
    // one stored duplex bit serves both select and polarity functions
    logic strap_duplex;
    logic strap_backpressure;
    logic strap_fd_flow;
    logic strap_manual_flow;
    logic strap_eee;
    logic next_strap_duplex;
    logic next_strap_backpressure;
    logic next_strap_fd_flow;
    logic next_strap_manual_flow;
    logic next_strap_eee;

    // pins are caught at the end of settle, eeprom bits replace them later
    always_comb begin
        next_strap_duplex = strap_duplex;
        next_strap_backpressure = strap_backpressure;
        next_strap_fd_flow = strap_fd_flow;
        next_strap_manual_flow = strap_manual_flow;
        next_strap_eee = strap_eee;
        if (state == psl_pkg::PSL_SETTLE && settle_done) begin
            next_strap_duplex = pins_sync[psl_pkg::PIN_DUPLEX_STRAP];
            next_strap_backpressure = pins_sync[psl_pkg::PIN_BACKPRESSURE];
            next_strap_fd_flow = pins_sync[psl_pkg::PIN_FD_FLOW];
            next_strap_manual_flow = pins_sync[psl_pkg::PIN_MANUAL_FLOW];
            next_strap_eee = pins_sync[psl_pkg::PIN_EEE];
        end else if (state == psl_pkg::PSL_WAIT_EEPROM && eeprom_strap_valid) begin
            // eee has no eeprom copy: it comes from its dedicated pin only
            next_strap_duplex = eeprom_duplex_strap;
            next_strap_backpressure = eeprom_backpressure_strap;
            next_strap_fd_flow = eeprom_fd_flow_strap;
            next_strap_manual_flow = eeprom_manual_flow_strap;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_duplex <= psl_pkg::DUPLEX_STRAP_RESET;
            strap_backpressure <= psl_pkg::BACKPRESSURE_STRAP_RESET;
            strap_fd_flow <= psl_pkg::FD_FLOW_STRAP_RESET;
            strap_manual_flow <= psl_pkg::MANUAL_FLOW_STRAP_RESET;
            strap_eee <= psl_pkg::EEE_STRAP_RESET;
        end else begin
            strap_duplex <= next_strap_duplex;
            strap_backpressure <= next_strap_backpressure;
            strap_fd_flow <= next_strap_fd_flow;
            strap_manual_flow <= next_strap_manual_flow;
            strap_eee <= next_strap_eee;
        end
    end

    // strap to default mapping
    // the mapper is pure logic and its result is used only in the load
    // cycle, so glitches while the modes change are harmless
    // the interface keeps the five strap bits together as one bundle
    psl_strap_if u_straps ();
    psl_pkg::psl_defaults_s mapped;

    assign u_straps.duplex = strap_duplex;
    assign u_straps.backpressure = strap_backpressure;
    assign u_straps.fd_flow = strap_fd_flow;
    assign u_straps.manual_flow = strap_manual_flow;
    assign u_straps.eee = strap_eee;

    psl_default_map u_map (
        .straps(u_straps),
        .port1_mode(port1_mode),
        .phya_fx_mode(phya_fx_mode),
        .defaults(mapped)
    );

    // default registers
    // limitation: modes are sampled once, in the load cycle; moving the
    // port or the phy into fx later leaves these defaults untouched
    // outputs come straight from these flops so no decode glitch reaches
    // the registers that they seed
    psl_pkg::psl_defaults_s defaults;
    psl_pkg::psl_defaults_s next_defaults;

    // defaults change only in the load cycle, so later mode changes do not disturb them
    always_comb begin
        next_defaults = defaults;
        if (state == psl_pkg::PSL_LOAD) begin
            next_defaults = mapped;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            defaults <= '0;
        end else begin
            defaults <= next_defaults;
        end
    end

    assign port1_backpressure_enable = defaults.backpressure_enable;
    assign port1_tx_flow_ctrl_enable = defaults.tx_flow_ctrl_enable;
    assign port1_rx_flow_ctrl_enable = defaults.rx_flow_ctrl_enable;
    assign port1_manual_flow_ctrl = defaults.manual_flow_ctrl;
    assign mac_energy_efficient_enable = defaults.energy_efficient_enable;
    assign phy_adv_asym_pause = defaults.phy_adv_asym_pause;
    assign phy_adv_sym_pause = defaults.phy_adv_sym_pause;
    assign virtual_phy_adv_asym_pause = defaults.vphy_adv_asym_pause;
    assign virtual_phy_adv_sym_pause = defaults.vphy_adv_sym_pause;
    assign virtual_phy_partner_ability = defaults.vphy_partner_ability;

    // duplex pin interpretation
    // unlike the defaults this path is live: the pin may change at any time
    // and is seen three edges later, two in the synchroniser and one here
    // it waits for ready so the polarity bit is the captured one, not the
    // fallback that stands before capture
    logic pin_full_duplex;
    logic next_pin_full_duplex;

    // full duplex when the pin level equals the polarity bit; outside the
    // mac modes the pin carries no meaning and reads as half duplex
    always_comb begin
        next_pin_full_duplex = 1'b0;
        if (state == psl_pkg::PSL_READY && psl_pkg::is_mac_mode(port1_mode)) begin
            next_pin_full_duplex = (pins_sync[psl_pkg::PIN_PORT1_DUPLEX] == strap_duplex);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_full_duplex <= 1'b0;
        end else begin
            pin_full_duplex <= next_pin_full_duplex;
        end
    end

    assign port1_pin_full_duplex = pin_full_duplex;

    // register access gate
    // trade-off: accept lags the request by one cycle, which costs a cycle
    // per access but keeps accept a clean flop output
    // a request raised before ready is not remembered; the requester keeps
    // it up until accept appears
    logic ready;
    logic accept;
    logic next_ready;
    logic next_accept;

    // ready rises the cycle after load, so no access can see stale defaults
    always_comb begin
        next_ready = (state == psl_pkg::PSL_LOAD) || (state == psl_pkg::PSL_READY);
        next_accept = reg_access_req && ready;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ready <= 1'b0;
            accept <= 1'b0;
        end else begin
            ready <= next_ready;
            accept <= next_accept;
        end
    end

    assign defaults_ready = ready;
    assign reg_access_accept = accept;

endmodule

// >>> sim/psl_strap_loader_chk.sv
// assertion checker for the port 1 strap default loader
`timescale 1ns/1ps
module psl_strap_loader_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // modes and access gate
    input wire psl_pkg::psl_port_mode_e port1_mode,
    input wire logic phya_fx_mode,
    input wire logic reg_access_req,
    input wire logic reg_access_accept,
    input wire logic defaults_ready,
    // defaults and duplex pin
    input wire logic port1_tx_flow_ctrl_enable,
    input wire logic port1_rx_flow_ctrl_enable,
    input wire logic port1_manual_flow_ctrl,
    input wire logic mac_energy_efficient_enable,
    input wire logic phy_adv_asym_pause,
    input wire logic phy_adv_sym_pause,
    input wire logic virtual_phy_adv_asym_pause,
    input wire logic virtual_phy_adv_sym_pause,
    input wire logic [psl_pkg::ABIL_W-1:0] virtual_phy_partner_ability,
    input wire logic port1_pin_full_duplex
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // helper terms: mac modes and the expected pause advertisement
    logic mac_mode;
    logic vpause;
    assign mac_mode = (port1_mode == psl_pkg::PSL_MODE_MII_MAC)
        || (port1_mode == psl_pkg::PSL_MODE_RMII_MAC);
    assign vpause = port1_tx_flow_ctrl_enable & ~port1_manual_flow_ctrl;

    sequence s_grant;
        reg_access_req && defaults_ready;
    endsequence
    sequence s_loaded;
        $rose(defaults_ready);
    endsequence

    a_grant_follows: assert property (s_grant |=> reg_access_accept)
        else $error("accept missing after ready request");
    a_no_early_accept: assert property (reg_access_accept |-> $past(reg_access_req) && $past(defaults_ready))
        else $error("accept without ready request");
    a_ready_holds: assert property (defaults_ready |=> defaults_ready)
        else $error("ready dropped");
    a_flow_pair: assert property (port1_tx_flow_ctrl_enable == port1_rx_flow_ctrl_enable)
        else $error("tx and rx flow enables differ");
    a_partner_duplex: assert property (defaults_ready |->
        virtual_phy_partner_ability[3] == virtual_phy_partner_ability[1]
        && virtual_phy_partner_ability[2] == virtual_phy_partner_ability[0]
        && virtual_phy_partner_ability[1] != virtual_phy_partner_ability[0])
        else $error("partner duplex bits inconsistent");
    a_partner_pause: assert property (defaults_ready |->
        virtual_phy_partner_ability[5:4] == {2{port1_tx_flow_ctrl_enable}})
        else $error("partner pause bits wrong");
    a_vphy_pause: assert property (defaults_ready |->
        virtual_phy_adv_asym_pause == vpause && virtual_phy_adv_sym_pause == vpause)
        else $error("virtual advertisement pause wrong");
    a_phy_fx_pause: assert property (s_loaded |->
        {phy_adv_asym_pause, phy_adv_sym_pause} == {2{vpause & ~$past(phya_fx_mode)}})
        else $error("phy advertisement pause wrong");
    a_eee_fx_off: assert property ($rose(defaults_ready) && $past(phya_fx_mode)
        && $past(port1_mode) == psl_pkg::PSL_MODE_INTERNAL_PHY |-> !mac_energy_efficient_enable)
        else $error("eee on with internal fx phy");
    a_pin_mode_gate: assert property (!$past(mac_mode) || !$past(defaults_ready) |->
        !port1_pin_full_duplex)
        else $error("duplex pin honoured outside mac modes");
endmodule

bind psl_strap_loader psl_strap_loader_chk u_chk (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .port1_mode(port1_mode),
    .phya_fx_mode(phya_fx_mode),
    .reg_access_req(reg_access_req),
    .reg_access_accept(reg_access_accept),
    .defaults_ready(defaults_ready),
    .port1_tx_flow_ctrl_enable(port1_tx_flow_ctrl_enable),
    .port1_rx_flow_ctrl_enable(port1_rx_flow_ctrl_enable),
    .port1_manual_flow_ctrl(port1_manual_flow_ctrl),
    .mac_energy_efficient_enable(mac_energy_efficient_enable),
    .phy_adv_asym_pause(phy_adv_asym_pause),
    .phy_adv_sym_pause(phy_adv_sym_pause),
    .virtual_phy_adv_asym_pause(virtual_phy_adv_asym_pause),
    .virtual_phy_adv_sym_pause(virtual_phy_adv_sym_pause),
    .virtual_phy_partner_ability(virtual_phy_partner_ability),
    .port1_pin_full_duplex(port1_pin_full_duplex)
);

// >>> sim/psl_strap_src.sv
// model of the strap pins and the eeprom strap image behind port 1
`timescale 1ns/1ps
module psl_strap_src (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // wanted levels: pins {eee, manual, fd, bp, duplex}, eeprom {manual, fd, bp, duplex}
    input wire logic [4:0] pin_cfg,
    input wire logic ee_present,
    input wire logic [3:0] ee_cfg,
    input wire logic [4:0] ee_delay,
    // strap pins and eeprom port
    output logic [4:0] pins,
    output logic eeprom_present,
    output logic eeprom_strap_valid,
    output logic [3:0] ee_bits
);
    logic [4:0] cnt;
    logic valid = 1'b0;

    // one duplex level feeds both select and polarity
    assign pins = pin_cfg;
    assign eeprom_present = ee_present;
    assign eeprom_strap_valid = valid;
    // bits outside the valid pulse are inverted so a sampling slip shows
    assign ee_bits = valid ? ee_cfg : ~ee_cfg;

    // cycles since reset release, saturating
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 5'h00;
        end else if (cnt != 5'h1f) begin
            cnt <= cnt + 5'h01;
        end
    end

    // one-cycle valid pulse, late by ee_delay cycles to model a slow eeprom
    always @(negedge ref_clk) begin
        valid <= ee_present && reset_n && (cnt == ee_delay);
    end
endmodule

// >>> sim/tb.sv
// self-checking bench for the port 1 strap default loader
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] pin_cfg = 5'h07;
    logic ee_present = 1'b0;
    logic [3:0] ee_cfg = 4'h0;
    logic [4:0] ee_delay = 5'h04;
    psl_pkg::psl_port_mode_e port1_mode = psl_pkg::PSL_MODE_MII_MAC;
    logic phya_fx_mode = 1'b0;
    logic reg_access_req = 1'b0;
    logic port1_duplex_pin = 1'b0;
    logic [4:0] pins;
    logic [3:0] ee_bits;
    logic ee_pres_w, ee_valid, accept, ready, bp_en, tx_en, rx_en, man_en, eee_en;
    logic pasym, psym, vasym, vsym, pin_fd;
    logic [5:0] abil;
    int err_count = 0;
    int checks_done = 0;
    // {fx, mode, eeprom bits, eeprom present, pins}
    logic [12:0] cases [6] = '{13'h0407, 13'h181c, 13'h1011, 13'h00b7, 13'h0c0a, 13'h1760};

    psl_strap_src u_src (.ref_clk(ref_clk), .reset_n(reset_n), .pin_cfg(pin_cfg),
        .ee_present(ee_present), .ee_cfg(ee_cfg), .ee_delay(ee_delay), .pins(pins),
        .eeprom_present(ee_pres_w), .eeprom_strap_valid(ee_valid), .ee_bits(ee_bits));

    psl_strap_loader dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .duplex_strap_pin(pins[0]), .port1_backpressure_strap(pins[1]),
        .port1_fullduplex_flow_ctrl_strap(pins[2]), .port1_manual_flow_ctrl_strap(pins[3]),
        .energy_efficient_strap_pin(pins[4]), .port1_duplex_pin(port1_duplex_pin),
        .eeprom_present(ee_pres_w), .eeprom_strap_valid(ee_valid),
        .eeprom_duplex_strap(ee_bits[0]), .eeprom_backpressure_strap(ee_bits[1]),
        .eeprom_fd_flow_strap(ee_bits[2]), .eeprom_manual_flow_strap(ee_bits[3]),
        .port1_mode(port1_mode), .phya_fx_mode(phya_fx_mode),
        .reg_access_req(reg_access_req), .reg_access_accept(accept), .defaults_ready(ready),
        .port1_backpressure_enable(bp_en), .port1_tx_flow_ctrl_enable(tx_en),
        .port1_rx_flow_ctrl_enable(rx_en), .port1_manual_flow_ctrl(man_en),
        .mac_energy_efficient_enable(eee_en), .phy_adv_asym_pause(pasym),
        .phy_adv_sym_pause(psym), .virtual_phy_adv_asym_pause(vasym),
        .virtual_phy_adv_sym_pause(vsym), .virtual_phy_partner_ability(abil),
        .port1_pin_full_duplex(pin_fd));

    // 200 MHz clock
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one strap setting: reset, wait for load, check defaults, gate and duplex pin
    task automatic run_case(input int idx);
        logic [12:0] c;
        logic [3:0] s;
        logic fx, vp, ex;
        int n;
        c = cases[idx];
        reset_n = 1'b0;
        pin_cfg = c[4:0];
        ee_present = c[5];
        ee_cfg = c[9:6];
        port1_mode = psl_pkg::psl_port_mode_e'(c[11:10]);
        phya_fx_mode = c[12];
        ee_delay = (idx == 5) ? 5'h0c : 5'h04;
        reg_access_req = 1'b1;
        port1_duplex_pin = 1'b0;
        fx = c[12];
        s = c[5] ? c[9:6] : c[3:0]; // eeprom image overrides the pins
        vp = s[2] & ~s[3];
        ex = c[4] & ~(c[11:10] == 2'h0 && fx);
        repeat (10) @(negedge ref_clk);
        reset_n = 1'b1;
        n = 0;
        while (ready !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
            compare(16'(accept & ~ready), 16'h0000);
        end
        if (!c[5]) compare(16'(n), 16'h0005);
        compare(16'({ready, accept}), 16'h0002);
        @(negedge ref_clk);
        compare(16'(accept), 16'h0001);
        reg_access_req = 1'b0;
        @(negedge ref_clk);
        compare(16'(accept), 16'h0000);
        compare(16'({bp_en, man_en}), 16'({s[1], s[3]}));
        compare(16'({tx_en, rx_en, vasym, vsym, abil}),
            16'({s[2], s[2], vp, vp, s[2], s[2], s[0], ~s[0], s[0], ~s[0]}));
        compare(16'({pasym, psym}), 16'({2{vp & ~fx}}));
        compare(16'(eee_en), 16'(ex));
        if (c[11:10] == 2'h0 || c[11:10] == 2'h3) begin
            port1_duplex_pin = ~s[0];
            repeat (4) @(negedge ref_clk);
            compare(16'(pin_fd), 16'h0000);
            port1_mode = psl_pkg::PSL_MODE_RMII_MAC;
        end
        for (int p = 0; p < 2; p++) begin
            port1_duplex_pin = p[0];
            repeat (4) @(negedge ref_clk);
            compare(16'(pin_fd), 16'(p[0] == s[0]));
        end
    endtask

    // main sequence
    initial begin
        @(negedge ref_clk);
        for (int i = 0; i < 6; i++) begin
            run_case(i);
        end
        complete_run();
    end

    // watchdog, far beyond the fewer than two hundred cycles the cases need
    initial begin
        #20000;
        err_count++;
        complete_run();
    end
endmodule
